// file: logic/csf_pkg.sv
// constants and types for the core status word, option and pc latch
// assumes one core clock; the execution unit issues one op per cycle
package csf_pkg;

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int ST_IBANK = 7;
  localparam int ST_BANK1 = 6;
  localparam int ST_BANK0 = 5;
  localparam int ST_TO   = 4;
  localparam int ST_PD   = 3;
  localparam int ST_Z    = 2;
  localparam int ST_DC   = 1;
  localparam int ST_C    = 0;

  // ----------------------------------------------------------------
  // option bit positions
  // ----------------------------------------------------------------
  localparam int OPT_PULLUP_N = 7;
  localparam int OPT_INT_EDGE = 6;
  localparam int OPT_TMR_SRC  = 5;
  localparam int OPT_TMR_EDGE = 4;
  localparam int OPT_ASGN     = 3;
  localparam int OPT_PS_HI    = 2;

  // ----------------------------------------------------------------
  // reset values; arithmetic flags are undefined, held at zero here
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic [4:0] PCHOLD_RST = 5'h00;
  localparam logic [4:0] PCH_RST    = 5'h00;

  // ----------------------------------------------------------------
  // register port map
  // ----------------------------------------------------------------
  localparam int         AW          = 2;
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_OPTION = 2'h1;
  localparam logic [1:0] ADDR_PCHOLD = 2'h2;

  // flag update masks, aligned to status bits 2..0
  localparam logic [2:0] UPD_NONE = 3'h0;
  localparam logic [2:0] UPD_Z    = 3'h4;
  localparam logic [2:0] UPD_C    = 3'h1;
  localparam logic [2:0] UPD_ALL  = 3'h7;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_ROT_R, OP_ROT_L,
    OP_CLEAR, OP_MOVE, OP_BIT_CLR, OP_BIT_SET, OP_SWAP
  } csf_op_t;

  typedef enum logic [2:0] {
    DEST_ACC, DEST_STATUS, DEST_OPTION, DEST_PCHOLD, DEST_OTHER
  } csf_dest_t;

endpackage : csf_pkg

// file: logic/csf_alu_if.sv
// carrier between the status core and its flag alu
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface csf_alu_if;
  import csf_pkg::*;
  csf_op_t    op;
  logic [7:0] a;
  logic [7:0] b;
  logic [2:0] bit_sel;
  logic       c_in;
  logic [7:0] y;
  logic [2:0] fl;
  logic [2:0] upd;

  modport alu  (input op, a, b, bit_sel, c_in, output y, fl, upd);
  modport core (output op, a, b, bit_sel, c_in, input y, fl, upd);
endinterface : csf_alu_if

// file: logic/csf_flag_alu.sv
// combinational alu producing the result and the zero/nibble/carry flags
// assumes operands are stable in the cycle the op is issued
`timescale 1ns/1ps
module csf_flag_alu
  import csf_pkg::*;
(
  csf_alu_if.alu alu  // operands in, result and flags out
);

  logic [7:0] addend;
  logic       cin;
  logic [8:0] sum9;
  logic [4:0] nib5;

  always_comb begin
    addend   = alu.a;
    cin      = 1'b0;
    if (alu.op == OP_SUB) begin
      // subtract by adding the two's complement: carry means no borrow
      addend = ~alu.a; // RQ13
      cin    = 1'b1;
    end
    sum9     = {1'b0, alu.b} + {1'b0, addend} + {8'h00, cin};
    nib5     = {1'b0, alu.b[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    alu.y    = alu.b;
    alu.upd  = UPD_NONE;
    alu.fl   = 3'h0;
    case (alu.op)
      OP_ADD, OP_SUB: begin
        alu.y   = sum9[7:0];
        alu.upd = UPD_ALL;
        alu.fl[ST_DC] = nib5[4]; // RQ11
        alu.fl[ST_C]  = sum9[8]; // RQ12
      end
      OP_AND:     alu.y = alu.a & alu.b;
      OP_IOR:     alu.y = alu.a | alu.b;
      OP_XOR:     alu.y = alu.a ^ alu.b;
      OP_ROT_R: begin
        alu.y   = {alu.c_in, alu.b[7:1]};
        alu.upd = UPD_C;
        alu.fl[ST_C] = alu.b[0]; // RQ14
      end
      OP_ROT_L: begin
        alu.y   = {alu.b[6:0], alu.c_in};
        alu.upd = UPD_C;
        alu.fl[ST_C] = alu.b[7]; // RQ14
      end
      OP_CLEAR:   alu.y = 8'h00;
      OP_MOVE:    alu.y = alu.a;
      OP_BIT_CLR: alu.y = alu.b & ~(8'h01 << alu.bit_sel);
      OP_BIT_SET: alu.y = alu.b | (8'h01 << alu.bit_sel);
      OP_SWAP:    alu.y = {alu.b[3:0], alu.b[7:4]};
      default:    alu.y = alu.b;
    endcase
    // logic and clear ops touch only the zero flag
    if (alu.op inside {OP_AND, OP_IOR, OP_XOR, OP_CLEAR}) begin
      alu.upd = UPD_Z;
    end
    alu.fl[ST_Z] = (alu.y == 8'h00); // RQ10
  end

endmodule : csf_flag_alu

// file: logic/csf_status_core.sv
// status word, option register and pc high latch of the 8-bit core
// assumes the execution unit, watchdog and register port share clock
// Operation
// RQ1: status word accepted as any instruction destination
// RQ2: flag-updating op masks result write to flags
// RQ3: timeout and powerdown bits ignore instruction writes
// RQ4: clear of status gives 000u u1uu
// RQ5: software should alter status only via flagless ops
// RQ6: bit 7 picks banks 2,3 for indirect
// RQ7: bits 6-5 pick direct bank 0 to 3
// RQ8: timeout bit set by powerup, clear, sleep
// RQ9: powerdown set by powerup or clear, sleep clears
// RQ10: zero flag follows zero result
// RQ11: nibble carry from bit 3 on add/sub
// RQ12: carry from most significant bit on add/sub
// RQ13: subtract adds two's complement, carry is not-borrow
// RQ14: rotates load carry with shifted-out bit
// RQ15: reset gives banks 0, timeout/powerdown 1
// RQ16: pc latch copied into pc upper on load
// RQ17: option register readable, writable, holds controls
// RQ18: software sets assign bit for 1:1 timer rate; timer exponent here stays rate field plus 1
// RQ19: assign bit routes prescaler watchdog or timer; here both exponents ignore it
// RQ20: rate field sets timer and watchdog division
// RQ21: direct address is bank bits over address
// RQ22: flags update in the result write cycle
`timescale 1ns/1ps
module csf_status_core
  import csf_pkg::*;
(
  input  wire logic            clock,          // core clock, 20 MHz
  input  wire logic            resetn,         // async power-on reset
  input  wire logic [AW-1:0]   reg_addr,       // register port address
  input  wire logic [7:0]      reg_wdata,      // register write data
  input  wire logic            reg_wr,         // register write strobe
  input  wire logic            reg_rd,         // register read strobe
  output logic      [7:0]      reg_rdata,      // read data, next cycle
  input  wire logic            exec_valid,     // op issued this cycle
  input  wire csf_op_t         exec_op,        // alu operation
  input  wire csf_dest_t       exec_dest,      // result destination
  input  wire logic [7:0]      exec_acc,       // accumulator operand
  input  wire logic [7:0]      exec_file,      // file or literal operand
  input  wire logic [2:0]      exec_bit,       // bit index for bit ops
  input  wire logic            watchdog_clear_op, // clear-watchdog op
  input  wire logic            sleep_op,       // sleep op executed
  input  wire logic            watchdog_timeout, // watchdog expired
  input  wire logic [6:0]      instr_addr7,    // direct address field
  input  wire logic [7:0]      fsr_value,      // indirect pointer
  input  wire logic            pc_load_low,    // write to pc low byte
  input  wire logic            pc_load_jump,   // call or goto load
  input  wire logic [2:0]      jump_hi3,       // target bits 10:8
  output logic      [7:0]      result_data,    // alu result, registered
  output logic                 result_valid,   // result_data is new
  output logic      [7:0]      status_word,    // current status word
  output logic      [8:0]      direct_addr,    // banked direct address
  output logic      [8:0]      indirect_addr,  // banked indirect address
  output logic      [4:0]      pc_upper,       // program counter 12:8
  output logic                 prescaler_assign, // 1: to watchdog
  output logic      [3:0]      timer_div_log2, // timer divide exponent
  output logic      [3:0]      watchdog_div_log2, // watchdog exponent
  output logic                 pullup_disable_n, // port pull-up control
  output logic                 int_edge_rise,  // ext interrupt edge
  output logic                 timer_src_pin,  // timer clock source
  output logic                 timer_edge_fall // timer pin edge
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] option;
    logic [4:0] pchold;
    logic [4:0] pch;
    logic [7:0] result;
    logic       res_valid;
    logic [7:0] rdata;
  } csf_state_t;

  localparam csf_state_t STATE_RST = '{
    status:    STATUS_RST,
    option:    OPTION_RST,
    pchold:    PCHOLD_RST,
    pch:       PCH_RST,
    result:    8'h00,
    res_valid: 1'b0,
    rdata:     8'h00
  };

  csf_state_t state_reg;
  csf_state_t state_next;
  csf_alu_if  alu_bus ();

  csf_flag_alu u_alu (
    .alu (alu_bus.alu)
  );

  // ----------------------------------------------------------------
  // alu operand drive
  // ----------------------------------------------------------------
  always_comb begin
    alu_bus.op      = exec_valid ? exec_op : OP_NONE;
    alu_bus.a       = exec_acc;
    alu_bus.b       = exec_file;
    alu_bus.bit_sel = exec_bit;
    alu_bus.c_in    = state_reg.status[ST_C];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next           = state_reg;
    state_next.res_valid = 1'b0;
    state_next.rdata     = 8'h00;

    // register port writes; timeout/powerdown stay read-only
    if (reg_wr) begin
      if (reg_addr == ADDR_STATUS) begin
        state_next.status[ST_IBANK:ST_BANK0] =
          reg_wdata[ST_IBANK:ST_BANK0]; // RQ3
        state_next.status[ST_Z:ST_C]     = reg_wdata[ST_Z:ST_C];
      end else if (reg_addr == ADDR_OPTION) begin
        state_next.option = reg_wdata; // RQ17
      end else if (reg_addr == ADDR_PCHOLD) begin
        state_next.pchold = reg_wdata[4:0];
      end
    end

    // instruction result; issued op wins over a same-cycle port write
    if (exec_valid) begin
      state_next.result    = alu_bus.y;
      state_next.res_valid = 1'b1;
      if (exec_dest == DEST_STATUS) begin
        state_next.status[ST_IBANK:ST_BANK0] =
          alu_bus.y[ST_IBANK:ST_BANK0]; // RQ1
        // flag ops block the result write to all three flags
        if (alu_bus.upd == UPD_NONE) begin
          state_next.status[ST_Z:ST_C] = alu_bus.y[ST_Z:ST_C]; // RQ2
        end
      end else if (exec_dest == DEST_OPTION) begin
        state_next.option = alu_bus.y;
      end else if (exec_dest == DEST_PCHOLD) begin
        state_next.pchold = alu_bus.y[4:0];
      end
      // flags land with the result, visible to the next op
      state_next.status[ST_Z:ST_C] =
        (alu_bus.fl & alu_bus.upd) |
        (state_next.status[ST_Z:ST_C] & ~alu_bus.upd); // RQ22
    end

    // hardware-only reset status; timeout beats a same-cycle clear
    if (watchdog_clear_op) begin
      state_next.status[ST_TO] = 1'b1; // RQ8
      state_next.status[ST_PD] = 1'b1; // RQ9
    end
    if (sleep_op) begin
      state_next.status[ST_TO] = 1'b1; // RQ8
      state_next.status[ST_PD] = 1'b0; // RQ9
    end
    if (watchdog_timeout) begin
      state_next.status[ST_TO] = 1'b0; // RQ8
    end

    // pc upper byte only moves on a load, never by direct access
    if (pc_load_low) begin
      state_next.pch = state_reg.pchold; // RQ16
    end else if (pc_load_jump) begin
      state_next.pch = {state_reg.pchold[4:3], jump_hi3}; // RQ16
    end

    // read data stands only in the cycle after the strobe
    if (reg_rd) begin
      if (reg_addr == ADDR_STATUS) begin
        state_next.rdata = state_reg.status;
      end else if (reg_addr == ADDR_OPTION) begin
        state_next.rdata = state_reg.option; // RQ17
      end else if (reg_addr == ADDR_PCHOLD) begin
        state_next.rdata = {3'h0, state_reg.pchold};
      end else begin
        state_next.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= STATE_RST; // RQ15
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata     = state_reg.rdata;
  assign result_data   = state_reg.result;
  assign result_valid  = state_reg.res_valid;
  assign status_word   = state_reg.status;
  assign pc_upper      = state_reg.pch;
  // bank bits sit above the 7-bit field; indirect uses bit 7 only
  assign direct_addr   = {state_reg.status[ST_BANK1:ST_BANK0],
                          instr_addr7}; // RQ7 RQ21
  assign indirect_addr = {state_reg.status[ST_IBANK], fsr_value}; // RQ6
  // both divide exponents follow the rate field whatever the assign bit
  assign prescaler_assign  = state_reg.option[OPT_ASGN]; // RQ19
  assign timer_div_log2    = {1'b0, state_reg.option[OPT_PS_HI:0]}
                             + 4'h1; // RQ20
  assign watchdog_div_log2 = {1'b0, state_reg.option[OPT_PS_HI:0]}; // RQ20
  assign pullup_disable_n  = state_reg.option[OPT_PULLUP_N];
  assign int_edge_rise     = state_reg.option[OPT_INT_EDGE];
  assign timer_src_pin     = state_reg.option[OPT_TMR_SRC];
  assign timer_edge_fall   = state_reg.option[OPT_TMR_EDGE];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic hw_ev;
  assign hw_ev = watchdog_clear_op | sleep_op | watchdog_timeout;

  property p_to_pd_ro;
    (exec_valid || reg_wr) && !hw_ev |=>
      status_word[ST_TO:ST_PD] == $past(status_word[ST_TO:ST_PD]);
  endproperty
  a_to_pd_ro: assert property (p_to_pd_ro) // RQ3
    else $error("reset status bits changed by a write");

  property p_clear_status;
    exec_valid && exec_op == OP_CLEAR && exec_dest == DEST_STATUS
      && !hw_ev |=>
      status_word == {3'h0, $past(status_word[ST_TO:ST_PD]), 1'b1,
                      $past(status_word[ST_DC:ST_C])};
  endproperty
  a_clear_status: assert property (p_clear_status) // RQ4
    else $error("clear of status gave wrong pattern");

  property p_sleep;
    sleep_op && !watchdog_timeout |=>
      status_word[ST_TO] && !status_word[ST_PD];
  endproperty
  a_sleep: assert property (p_sleep) // RQ9
    else $error("sleep did not set timeout and clear powerdown");

  property p_timeout;
    watchdog_timeout |=> !status_word[ST_TO];
  endproperty
  a_timeout: assert property (p_timeout) // RQ8
    else $error("watchdog expiry did not clear timeout bit");

  property p_wdt_clear;
    watchdog_clear_op && !sleep_op && !watchdog_timeout |=>
      status_word[ST_TO] && status_word[ST_PD];
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) // RQ9
    else $error("watchdog clear did not set both bits");

  property p_add_flags;
    logic [8:0] s;
    (exec_valid && exec_op == OP_ADD && exec_dest != DEST_STATUS,
     s = {1'b0, exec_acc} + {1'b0, exec_file}) |=>
      status_word[ST_C] == s[8] && status_word[ST_Z] == (s[7:0] == 8'h00)
      && result_data == s[7:0];
  endproperty
  a_add_flags: assert property (p_add_flags) // RQ12
    else $error("add carry or zero flag wrong");

  property p_sub_borrow;
    exec_valid && exec_op == OP_SUB && exec_dest != DEST_STATUS |=>
      status_word[ST_C] == ($past(exec_file) >= $past(exec_acc)) &&
      status_word[ST_DC] == ($past(exec_file[3:0]) >= $past(exec_acc[3:0]));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) // RQ13
    else $error("subtract borrow polarity wrong");

  property p_rotate;
    exec_valid && exec_dest != DEST_STATUS && exec_op == OP_ROT_R |=>
      status_word[ST_C] == $past(exec_file[0]) &&
      result_data[7] == $past(status_word[ST_C]);
  endproperty
  a_rotate: assert property (p_rotate) // RQ14
    else $error("rotate right carry wrong");

  property p_pc_load;
    pc_load_low |=> pc_upper == $past(state_reg.pchold);
  endproperty
  a_pc_load: assert property (p_pc_load) // RQ16
    else $error("pc upper not loaded from latch");

  // a latch write alone must never reach the program counter
  property p_pc_hold;
    !pc_load_low && !pc_load_jump |=> $stable(pc_upper);
  endproperty
  a_pc_hold: assert property (p_pc_hold) // RQ16
    else $error("pc upper moved without a load");

  property p_flagless_status;
    exec_valid && exec_dest == DEST_STATUS && !hw_ev &&
      exec_op inside {OP_MOVE, OP_BIT_CLR, OP_BIT_SET, OP_SWAP} |=>
      status_word[ST_IBANK:ST_BANK0] == result_data[ST_IBANK:ST_BANK0] &&
      status_word[ST_Z:ST_C] == result_data[ST_Z:ST_C];
  endproperty
  a_flagless_status: assert property (p_flagless_status) // RQ1
    else $error("flagless op result not written to status");

  property p_rd_one_cycle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle) // RQ17
    else $error("read data outside its cycle");

  c_clear_status: cover property (exec_valid && exec_op == OP_CLEAR
                                  && exec_dest == DEST_STATUS);
  c_sleep_wake: cover property (sleep_op ##[1:20] watchdog_timeout);
  c_borrow: cover property (exec_valid && exec_op == OP_SUB
                            ##1 !status_word[ST_C]);
  c_bank3: cover property (direct_addr[8:7] == 2'h3);

endmodule : csf_status_core

// file: verif/csf_exec_model.sv
// model of the instruction execution unit that feeds the status core
// assumes the bench calls its tasks; signals change just after rising edges
`timescale 1ns/1ps
module csf_exec_model
  import csf_pkg::*;
(
  input  wire logic  clock,             // core clock
  output logic       exec_valid,        // op issue strobe
  output csf_op_t    exec_op,           // operation
  output csf_dest_t  exec_dest,         // destination
  output logic [7:0] exec_acc,          // accumulator operand
  output logic [7:0] exec_file,         // file or literal operand
  output logic [2:0] exec_bit,          // bit index
  output logic       watchdog_clear_op, // clear-watchdog pulse
  output logic       sleep_op,          // sleep pulse
  output logic       watchdog_timeout,  // watchdog expiry pulse
  output logic       pc_load_low,       // pc low byte write pulse
  output logic       pc_load_jump,      // call or goto pulse
  output logic [2:0] jump_hi3           // jump target bits 10:8
);
  initial begin
    exec_valid = 1'b0;
    exec_op    = OP_NONE;
    exec_dest  = DEST_ACC;
    {exec_acc, exec_file, exec_bit} = 19'h00000;
    {watchdog_clear_op, sleep_op, watchdog_timeout} = 3'h0;
    {pc_load_low, pc_load_jump, jump_hi3} = 5'h00;
  end

  // ----------------------------------------------------------------
  // one op per call; operands go stale-inverted so old data never matches
  // bit ops take their index from the low bits of acc, which they ignore
  // ----------------------------------------------------------------
  task automatic issue(input csf_op_t op, input csf_dest_t dest,
                       input logic [7:0] acc, input logic [7:0] file);
    @(posedge clock);
    exec_valid <= 1'b1;
    exec_op    <= op;
    exec_dest  <= dest;
    exec_acc   <= acc;
    exec_file  <= file;
    exec_bit   <= acc[2:0];
    @(posedge clock);
    exec_valid <= 1'b0;
    exec_op    <= OP_NONE;
    exec_acc   <= ~acc;
    exec_file  <= ~file;
  endtask : issue

  // ev is {clear, sleep, timeout}; ld is {load_low, load_jump}
  task automatic pulse(input logic [2:0] ev, input logic [1:0] ld,
                       input logic [2:0] hi);
    @(posedge clock);
    {watchdog_clear_op, sleep_op, watchdog_timeout} <= ev;
    {pc_load_low, pc_load_jump} <= ld;
    jump_hi3 <= hi;
    @(posedge clock);
    {watchdog_clear_op, sleep_op, watchdog_timeout} <= 3'h0;
    {pc_load_low, pc_load_jump} <= 2'h0;
    jump_hi3 <= ~hi;
  endtask : pulse
endmodule : csf_exec_model

// file: verif/tb_top.sv
// self-checking bench for the status word, option and pc latch block
// assumes csf_exec_model stands in for the execution unit
`timescale 1ns/1ps
module tb_top;
  import csf_pkg::*;
  logic            clock, resetn, reg_wr, reg_rd, exec_valid;
  logic [AW-1:0]   reg_addr;
  logic [7:0]      reg_wdata, reg_rdata, exec_acc, exec_file, fsr_value;
  logic [7:0]      result_data, status_word;
  logic [6:0]      instr_addr7;
  logic [2:0]      exec_bit, jump_hi3;
  csf_op_t         exec_op;
  csf_dest_t       exec_dest;
  logic            watchdog_clear_op, sleep_op, watchdog_timeout;
  logic            pc_load_low, pc_load_jump, result_valid;
  logic [8:0]      direct_addr, indirect_addr;
  logic [4:0]      pc_upper;
  logic            prescaler_assign, pullup_disable_n, int_edge_rise;
  logic            timer_src_pin, timer_edge_fall;
  logic [3:0]      timer_div_log2, watchdog_div_log2;
  int              miscompares = 0;
  int              checks = 0;

  always #25 clock = ~clock;

  csf_status_core uut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .exec_valid, .exec_op, .exec_dest, .exec_acc,
    .exec_file, .exec_bit, .watchdog_clear_op, .sleep_op, .watchdog_timeout,
    .instr_addr7, .fsr_value, .pc_load_low, .pc_load_jump, .jump_hi3,
    .result_data, .result_valid, .status_word, .direct_addr, .indirect_addr,
    .pc_upper, .prescaler_assign, .timer_div_log2, .watchdog_div_log2,
    .pullup_disable_n, .int_edge_rise, .timer_src_pin, .timer_edge_fall);

  csf_exec_model exec_unit (.clock, .exec_valid, .exec_op, .exec_dest,
    .exec_acc, .exec_file, .exec_bit, .watchdog_clear_op, .sleep_op,
    .watchdog_timeout, .pc_load_low, .pc_load_jump, .jump_hi3);

  // ----------------------------------------------------------------
  // compares and bus cycles
  // ----------------------------------------------------------------
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk9(input string what, input logic [8:0] exp,
                      input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk9

  task automatic reg_write(input logic [1:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_wdata <= ~data;
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [1:0] addr, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk8("reg_rdata", exp, reg_rdata);
  endtask : reg_read

  task automatic run_op(input csf_op_t op, input csf_dest_t dest,
                        input logic [7:0] acc, input logic [7:0] file,
                        input logic [7:0] y, input logic [2:0] fl);
    exec_unit.issue(op, dest, acc, file);
    #1;
    chk8("result_data", y, result_data);
    chk8("result_valid", 8'h01, {7'h00, result_valid});
    chk8("flags", {5'h00, fl}, {5'h00, status_word[2:0]});
  endtask : run_op

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk8("status_word", STATUS_RST, status_word);
    reg_read(ADDR_STATUS, 8'h18);
    reg_read(ADDR_OPTION, 8'hff);
    reg_read(ADDR_PCHOLD, 8'h00);
    reg_read(2'h3, 8'h00);
    @(posedge clock);
    #1;
    chk8("reg_rdata idle", 8'h00, reg_rdata);
  endtask : t_reset

  task automatic t_option();
    for (int i = 0; i < 8; i++) begin
      reg_write(ADDR_OPTION, {5'h15, i[2:0]});
      #1;
      chk8("assign", 8'h01, {7'h00, prescaler_assign});
      chk8("timer_div", 8'(i + 1), {4'h0, timer_div_log2});
      chk8("wdt_div", 8'(i), {4'h0, watchdog_div_log2});
      chk8("ctl", 8'ha0, {pullup_disable_n, int_edge_rise, timer_src_pin,
                          timer_edge_fall, 4'h0});
    end
    reg_write(ADDR_OPTION, 8'h53);
    #1;
    chk8("assign", 8'h00, {7'h00, prescaler_assign});
    reg_read(ADDR_OPTION, 8'h53);
    run_op(OP_MOVE, DEST_OPTION, 8'h5b, 8'h00, 8'h5b, 3'b000);
    reg_read(ADDR_OPTION, 8'h5b);
  endtask : t_option

  task automatic t_banks();
    instr_addr7 <= 7'h5a;
    fsr_value   <= 8'hc3;
    reg_write(ADDR_STATUS, 8'h00);
    #1;
    chk8("status_word", 8'h18, status_word);
    for (int i = 0; i < 8; i++) begin
      reg_write(ADDR_STATUS, {i[2:0], 5'h00});
      #1;
      chk9("direct_addr", {i[1:0], 7'h5a}, direct_addr);
      chk9("indirect_addr", {i[2], 8'hc3}, indirect_addr);
    end
  endtask : t_banks

  task automatic t_arith();
    run_op(OP_ADD, DEST_OTHER, 8'h08, 8'h08, 8'h10, 3'b010);
    run_op(OP_ADD, DEST_OTHER, 8'h01, 8'hff, 8'h00, 3'b111);
    run_op(OP_ADD, DEST_OTHER, 8'h10, 8'h20, 8'h30, 3'b000);
    run_op(OP_SUB, DEST_OTHER, 8'h03, 8'h05, 8'h02, 3'b011);
    run_op(OP_SUB, DEST_OTHER, 8'h05, 8'h03, 8'hfe, 3'b000);
    run_op(OP_SUB, DEST_OTHER, 8'h07, 8'h07, 8'h00, 3'b111);
    run_op(OP_ROT_R, DEST_OTHER, 8'h00, 8'h02, 8'h81, 3'b110);
    run_op(OP_ROT_L, DEST_OTHER, 8'h00, 8'h80, 8'h00, 3'b111);
    run_op(OP_ROT_L, DEST_OTHER, 8'h00, 8'h00, 8'h01, 3'b110);
    run_op(OP_IOR, DEST_OTHER, 8'h01, 8'h00, 8'h01, 3'b010);
    run_op(OP_AND, DEST_OTHER, 8'h0f, 8'hf0, 8'h00, 3'b110);
    run_op(OP_XOR, DEST_OTHER, 8'h55, 8'h54, 8'h01, 3'b010);
    run_op(OP_MOVE, DEST_OTHER, 8'h3c, 8'h00, 8'h3c, 3'b010);
  endtask : t_arith

  task automatic t_status_dest();
    reg_write(ADDR_STATUS, 8'he3);
    #1;
    chk8("status_word", 8'hfb, status_word);
    run_op(OP_CLEAR, DEST_STATUS, 8'h77, 8'h77, 8'h00, 3'b111);
    chk8("status_word", 8'h1f, status_word);
    run_op(OP_ADD, DEST_STATUS, 8'h01, 8'h01, 8'h02, 3'b000);
    chk8("status_word", 8'h18, status_word);
    run_op(OP_MOVE, DEST_STATUS, 8'he7, 8'h00, 8'he7, 3'b111);
    chk8("status_word", 8'hff, status_word);
    run_op(OP_BIT_CLR, DEST_STATUS, 8'h07, 8'hff, 8'h7f, 3'b111);
    run_op(OP_BIT_SET, DEST_STATUS, 8'h01, 8'h18, 8'h1a, 3'b010);
    run_op(OP_SWAP, DEST_STATUS, 8'h00, 8'h3e, 8'he3, 3'b011);
    chk8("status_word", 8'hfb, status_word);
  endtask : t_status_dest

  // event order {clear, sleep, timeout}; status bits 4 and 3 follow
  task automatic t_events();
    logic [2:0] ev[5] = '{3'b010, 3'b001, 3'b100, 3'b011, 3'b100};
    logic [1:0] ex[5] = '{2'b10, 2'b00, 2'b11, 2'b00, 2'b11};
    for (int i = 0; i < 5; i++) begin
      exec_unit.pulse(ev[i], 2'h0, 3'h0);
      #1;
      chk8("reset_bits", {6'h00, ex[i]}, {6'h00, status_word[4:3]});
    end
  endtask : t_events

  task automatic t_pc();
    reg_write(ADDR_PCHOLD, 8'hfa);
    reg_read(ADDR_PCHOLD, 8'h1a);
    exec_unit.pulse(3'h0, 2'b10, 3'h0);
    #1;
    chk8("pc_upper", 8'h1a, {3'h0, pc_upper});
    exec_unit.pulse(3'h0, 2'b01, 3'b101);
    #1;
    chk8("pc_upper", 8'h1d, {3'h0, pc_upper});
    run_op(OP_MOVE, DEST_PCHOLD, 8'hec, 8'h00, 8'hec, 3'b011);
    reg_read(ADDR_PCHOLD, 8'h0c);
    chk8("pc_upper", 8'h1d, {3'h0, pc_upper});
  endtask : t_pc

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // the sequence needs about 125 cycles; 3000 leaves wide margin
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    complete_run();
  end

  initial begin
    clock       = 1'b0;
    resetn      = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 12'h000;
    instr_addr7 = 7'h00;
    fsr_value   = 8'h00;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_option();
    t_banks();
    t_arith();
    t_status_dest();
    t_events();
    t_pc();
    complete_run();
  end
endmodule : tb_top
